/* File: include/flash_ctl_consts.svh */
`ifndef FLASH_CTL_CONSTS_SVH
`define FLASH_CTL_CONSTS_SVH

`define FL_AW          19
`define FL_DW          16
`define TIMER_W        21

`define ADDR_UNLOCK1   19'h05555
`define ADDR_UNLOCK2   19'h02AAA
`define ADDR_ANY       19'h00000

`define CODE_AA        16'h00AA
`define CODE_55        16'h0055
`define CODE_PROG      16'h00A0
`define CODE_ERASE     16'h0080
`define CODE_SECTOR    16'h0030
`define CODE_BLOCK     16'h0050
`define CODE_CHIP      16'h0010
`define CODE_ID        16'h0090
`define CODE_QUERY     16'h0098
`define CODE_EXIT      16'h00F0
`define ERASED_BIT     1'h1

`define STEP_0         3'h0
`define STEP_1         3'h1
`define STEP_2         3'h2
`define STEP_3         3'h3
`define STEP_4         3'h4
`define STEP_5         3'h5

`define POLL_BIT       7
`define TOGGLE_BIT     6
`define CONFIRM_N      2'h2

`define CLK_NS         100
`define WE_PULSE_NS    5
`define RD_CYCLE_NS    90
`define SYNC_STAGES    2
`define PROG_MAX_NS    20000
`define ERASE_MAX_MS   200
`define NS_PER_MS      1000000

`define WE_CYC         ((`WE_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_CYC         ((`RD_CYCLE_NS + `CLK_NS - 1) / `CLK_NS + `SYNC_STAGES)
`define PROG_CYC       (`PROG_MAX_NS / `CLK_NS)
`define ERASE_CYC      (`ERASE_MAX_MS * `NS_PER_MS / `CLK_NS)

`endif

/* File: include/flash_ctl_pkg.sv */
`include "flash_ctl_consts.svh"

package flash_ctl_pkg;

    typedef enum logic [2:0] {
        OP_READ         = 3'h0,
        OP_PROGRAM      = 3'h1,
        OP_SECTOR_ERASE = 3'h2,
        OP_BLOCK_ERASE  = 3'h3,
        OP_CHIP_ERASE   = 3'h4,
        OP_ID_ENTRY     = 3'h5,
        OP_QUERY_ENTRY  = 3'h6,
        OP_MODE_EXIT    = 3'h7
    } flash_op_e;

    typedef struct packed {
        logic                  write;
        logic [`FL_AW-1:0]     addr;
        logic [`FL_DW-1:0]     data;
    } cyc_s;

    typedef struct packed {
        logic                  ce_n;
        logic                  oe_n;
        logic                  we_n;
        logic [`FL_AW-1:0]     addr;
        logic [`FL_DW-1:0]     dq_out;
        logic                  dq_oe_n;
    } pins_s;

    typedef enum logic [1:0] {
        E_IDLE  = 2'b00,
        E_SETUP = 2'b01,
        E_ACT   = 2'b10,
        E_HOLD  = 2'b11
    } eng_state_e;

    typedef struct packed {
        eng_state_e            st;
        logic                  wr;
        logic [1:0]            cnt;
        logic                  ack;
        logic [`FL_DW-1:0]     rd_data;
        logic [`FL_DW-1:0]     sync1;
        logic [`FL_DW-1:0]     sync2;
        pins_s                 pins;
    } eng_s;

    typedef enum logic [1:0] {
        T_IDLE  = 2'b00,
        T_ISSUE = 2'b01,
        T_WAIT  = 2'b10
    } top_state_e;

    typedef struct packed {
        top_state_e            st;
        flash_op_e             op;
        logic [`FL_AW-1:0]     addr;
        logic [`FL_DW-1:0]     data;
        logic [2:0]            idx;
        logic                  polling;
        logic                  req_valid;
        cyc_s                  req;
        logic [1:0]            good;
        logic                  last6;
        logic                  have_last;
        logic [`TIMER_W-1:0]   timer;
        logic                  ready;
        logic                  done;
        logic [`FL_DW-1:0]     rdata;
        logic                  timed_out;
    } top_s;

endpackage

/* File: hdl/bus_cycle_engine.sv */
`timescale 1ns/100ps
`include "flash_ctl_consts.svh"

module bus_cycle_engine (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // cycle request
    input  wire logic                  req_valid,
    input  flash_ctl_pkg::cyc_s        req,
    output logic                       ack,
    output logic [`FL_DW-1:0]          rd_data,
    // flash pins
    output flash_ctl_pkg::pins_s       pins,
    input  wire logic [`FL_DW-1:0]     dq_in
);

    flash_ctl_pkg::eng_s q;
    flash_ctl_pkg::eng_s d;

    always_comb begin
        d       = q;
        d.ack   = 1'b0;
        d.sync1 = dq_in;
        d.sync2 = q.sync1;
        case (q.st)
            flash_ctl_pkg::E_IDLE: begin
                if (req_valid) begin
                    // address and data settle a cycle before any strobe falls
                    d.pins.addr    = req.addr;
                    d.pins.dq_out  = req.data;
                    d.pins.dq_oe_n = ~req.write;
                    d.wr           = req.write;
                    d.st           = flash_ctl_pkg::E_SETUP;
                end
            end
            flash_ctl_pkg::E_SETUP: begin
                d.pins.ce_n = 1'b0;
                if (q.wr) begin
                    d.pins.we_n = 1'b0;
                    d.cnt       = 2'(`WE_CYC - 1);
                end else begin
                    d.pins.oe_n = 1'b0;
                    d.cnt       = 2'(`RD_CYC - 1);
                end
                d.st = flash_ctl_pkg::E_ACT;
            end
            flash_ctl_pkg::E_ACT: begin
                if (q.cnt == 2'h0) begin
                    if (!q.wr) begin
                        d.rd_data = q.sync2;
                    end
                    d.pins.ce_n = 1'b1;
                    d.pins.we_n = 1'b1;
                    d.pins.oe_n = 1'b1;
                    d.st        = flash_ctl_pkg::E_HOLD;
                end else begin
                    d.cnt = q.cnt - 2'h1;
                end
            end
            flash_ctl_pkg::E_HOLD: begin
                // data held past the strobe rise, released one cycle later
                d.pins.dq_oe_n = 1'b1;
                d.ack          = 1'b1;
                d.st           = flash_ctl_pkg::E_IDLE;
            end
            default: begin
                d.st = flash_ctl_pkg::E_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q              <= '0;
            q.st           <= flash_ctl_pkg::E_IDLE;
            q.pins.ce_n    <= 1'b1;
            q.pins.oe_n    <= 1'b1;
            q.pins.we_n    <= 1'b1;
            q.pins.dq_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign ack     = q.ack;
    assign rd_data = q.rd_data;
    assign pins    = q.pins;

    a_strobe_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !q.pins.we_n |-> (q.pins.oe_n && !q.pins.ce_n && !q.pins.dq_oe_n))
        else $error("write strobe without chip select or with output enable");

    a_write_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(q.pins.we_n) |-> ($stable(q.pins.addr) && $stable(q.pins.dq_out)
                                && !q.pins.dq_oe_n))
        else $error("address or data moved at write strobe rise");

endmodule

/* File: hdl/flash_host_ctl.sv */
`timescale 1ns/100ps
`include "flash_ctl_consts.svh"

module flash_host_ctl #(
    parameter int unsigned ERASE_LIMIT = `ERASE_CYC
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // user command port
    input  wire logic                  cmd_valid,
    input  flash_ctl_pkg::flash_op_e   cmd_op,
    input  wire logic [`FL_AW-1:0]     cmd_addr,
    input  wire logic [`FL_DW-1:0]     cmd_data,
    output logic                       cmd_ready,
    output logic                       done,
    output logic [`FL_DW-1:0]          rd_word,
    output logic                       timed_out,
    // flash pins
    output flash_ctl_pkg::pins_s       flash_pins,
    input  wire logic [`FL_DW-1:0]     flash_dq_in
);

    flash_ctl_pkg::top_s q;
    flash_ctl_pkg::top_s d;
    logic                eng_ack;
    logic [`FL_DW-1:0]   eng_rd;
    logic                is_last;
    logic                is_write_op;
    logic                exp7;
    logic                status_ok;

    function automatic logic [2:0] last_step(input flash_ctl_pkg::flash_op_e op);
        case (op)
            flash_ctl_pkg::OP_PROGRAM:     last_step = `STEP_3;
            flash_ctl_pkg::OP_ID_ENTRY,
            flash_ctl_pkg::OP_QUERY_ENTRY: last_step = `STEP_2;
            flash_ctl_pkg::OP_SECTOR_ERASE,
            flash_ctl_pkg::OP_BLOCK_ERASE,
            flash_ctl_pkg::OP_CHIP_ERASE:  last_step = `STEP_5;
            default:                       last_step = `STEP_0;
        endcase
    endfunction

    function automatic flash_ctl_pkg::cyc_s step(input flash_ctl_pkg::flash_op_e op,
                                                 input logic [2:0]          i,
                                                 input logic [`FL_AW-1:0]   a,
                                                 input logic [`FL_DW-1:0]   v);
        step = '{write: 1'b1, addr: `ADDR_UNLOCK1, data: `CODE_AA};
        case (op)
            flash_ctl_pkg::OP_READ: begin
                step = '{write: 1'b0, addr: a, data: '0};
            end
            flash_ctl_pkg::OP_MODE_EXIT: begin
                step = '{write: 1'b1, addr: `ADDR_ANY, data: `CODE_EXIT};
            end
            default: begin
                case (i)
                    `STEP_1, `STEP_4: step = '{write: 1'b1, addr: `ADDR_UNLOCK2,
                                               data: `CODE_55};
                    `STEP_2: begin
                        case (op)
                            flash_ctl_pkg::OP_PROGRAM:     step.data = `CODE_PROG;
                            flash_ctl_pkg::OP_ID_ENTRY:    step.data = `CODE_ID;
                            flash_ctl_pkg::OP_QUERY_ENTRY: step.data = `CODE_QUERY;
                            default:                       step.data = `CODE_ERASE;
                        endcase
                    end
                    `STEP_3: begin
                        if (op == flash_ctl_pkg::OP_PROGRAM) begin
                            step = '{write: 1'b1, addr: a, data: v};
                        end
                    end
                    `STEP_5: begin
                        case (op)
                            flash_ctl_pkg::OP_SECTOR_ERASE:
                                step = '{write: 1'b1, addr: a, data: `CODE_SECTOR};
                            flash_ctl_pkg::OP_BLOCK_ERASE:
                                step = '{write: 1'b1, addr: a, data: `CODE_BLOCK};
                            default:
                                step = '{write: 1'b1, addr: `ADDR_UNLOCK1,
                                         data: `CODE_CHIP};
                        endcase
                    end
                    default: begin
                        step = '{write: 1'b1, addr: `ADDR_UNLOCK1, data: `CODE_AA};
                    end
                endcase
            end
        endcase
    endfunction

    bus_cycle_engine u_engine (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .req_valid (q.req_valid),
        .req       (q.req),
        .ack       (eng_ack),
        .rd_data   (eng_rd),
        .pins      (flash_pins),
        .dq_in     (flash_dq_in)
    );

    assign is_last     = (q.idx == last_step(q.op));
    assign is_write_op = (q.op == flash_ctl_pkg::OP_PROGRAM) ||
                         (q.op == flash_ctl_pkg::OP_SECTOR_ERASE) ||
                         (q.op == flash_ctl_pkg::OP_BLOCK_ERASE) ||
                         (q.op == flash_ctl_pkg::OP_CHIP_ERASE);
    // erase finishes with the poll bit high, program with the true data bit
    assign exp7        = (q.op == flash_ctl_pkg::OP_PROGRAM) ? q.data[`POLL_BIT] : `ERASED_BIT;
    // a read counts only when both status bits agree the device is ready
    assign status_ok   = (eng_rd[`POLL_BIT] == exp7) && q.have_last &&
                         (eng_rd[`TOGGLE_BIT] == q.last6);

    always_comb begin
        d           = q;
        d.req_valid = 1'b0;
        d.done      = 1'b0;
        case (q.st)
            flash_ctl_pkg::T_IDLE: begin
                if (cmd_valid) begin
                    // refused until the running command ends
                    d.op        = cmd_op;
                    d.addr      = cmd_addr;
                    d.data      = cmd_data;
                    d.idx       = `STEP_0;
                    d.polling   = 1'b0;
                    d.timed_out = 1'b0;
                    d.ready     = 1'b0;
                    d.st        = flash_ctl_pkg::T_ISSUE;
                end
            end
            flash_ctl_pkg::T_ISSUE: begin
                d.req_valid = 1'b1;
                d.req       = q.polling ? flash_ctl_pkg::cyc_s'{write: 1'b0, addr: q.addr,
                                                                data: '0}
                                        : step(q.op, q.idx, q.addr, q.data);
                d.st        = flash_ctl_pkg::T_WAIT;
            end
            flash_ctl_pkg::T_WAIT: begin
                if (q.polling && q.timer != '0) begin
                    d.timer = q.timer - `TIMER_W'(1);
                end
                if (eng_ack) begin
                    d.st = flash_ctl_pkg::T_ISSUE;
                    if (q.polling) begin
                        d.last6     = eng_rd[`TOGGLE_BIT];
                        d.have_last = 1'b1;
                        if (status_ok && q.good == `CONFIRM_N) begin
                            d.done  = 1'b1;
                            d.rdata = eng_rd;
                            d.ready = 1'b1;
                            d.st    = flash_ctl_pkg::T_IDLE;
                        end else if (q.timer == '0) begin
                            d.done      = 1'b1;
                            d.timed_out = 1'b1;
                            d.rdata     = eng_rd;
                            d.ready     = 1'b1;
                            d.st        = flash_ctl_pkg::T_IDLE;
                        end else begin
                            d.good = status_ok ? q.good + 2'h1 : 2'h0;
                        end
                    end else if (!is_last) begin
                        d.idx = q.idx + 3'h1;
                    end else if (is_write_op) begin
                        // status is valid only after the launching write
                        d.polling   = 1'b1;
                        d.good      = 2'h0;
                        d.have_last = 1'b0;
                        d.timer     = (q.op == flash_ctl_pkg::OP_PROGRAM) ?
                                      `TIMER_W'(`PROG_CYC) : `TIMER_W'(ERASE_LIMIT);
                    end else begin
                        d.done  = 1'b1;
                        d.rdata = eng_rd;
                        d.ready = 1'b1;
                        d.st    = flash_ctl_pkg::T_IDLE;
                    end
                end
            end
            default: begin
                d.st = flash_ctl_pkg::T_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q       <= '0;
            q.st    <= flash_ctl_pkg::T_IDLE;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign cmd_ready = q.ready;
    assign done      = q.done;
    assign rd_word   = q.rdata;
    assign timed_out = q.timed_out;

    a_unlock_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.req_valid && !q.polling && q.idx == `STEP_0 && q.op != flash_ctl_pkg::OP_READ
         && q.op != flash_ctl_pkg::OP_MODE_EXIT)
        |-> (q.req.addr == `ADDR_UNLOCK1 && q.req.data == `CODE_AA))
        else $error("first unlock write wrong");

    a_unlock_second: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.req_valid && !q.polling && (q.idx == `STEP_1 || q.idx == `STEP_4))
        |-> (q.req.addr == `ADDR_UNLOCK2 && q.req.data == `CODE_55 && q.req.write))
        else $error("second unlock write wrong");

    a_block_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.req_valid && !q.polling && q.idx == `STEP_5
         && q.op == flash_ctl_pkg::OP_BLOCK_ERASE)
        |-> (q.req.data == `CODE_BLOCK && q.req.addr == q.addr))
        else $error("block erase final write wrong");

    a_chip_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.req_valid && !q.polling && q.idx == `STEP_5
         && q.op == flash_ctl_pkg::OP_CHIP_ERASE)
        |-> (q.req.data == `CODE_CHIP && q.req.addr == `ADDR_UNLOCK1))
        else $error("chip erase final write wrong");

    a_query_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.req_valid && q.idx == `STEP_2 && q.op == flash_ctl_pkg::OP_QUERY_ENTRY)
        |-> (q.req.data == `CODE_QUERY && q.req.addr == `ADDR_UNLOCK1)
        ##1 (!q.req_valid [*3])) 
        else $error("query entry write wrong");

    a_exit_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.req_valid && q.op == flash_ctl_pkg::OP_MODE_EXIT)
        |-> (q.req.write && q.req.data == `CODE_EXIT))
        else $error("exit command wrong");

    a_erase_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($rose(q.polling) && q.op != flash_ctl_pkg::OP_PROGRAM) |-> $past(q.idx) == `STEP_5)
        else $error("erase launched before sixth write");

    a_poll_confirm: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.done && q.polling && !q.timed_out) |-> $past(q.good) == `CONFIRM_N)
        else $error("completion taken without two confirming rereads");

    a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (q.st != flash_ctl_pkg::T_IDLE) |-> !q.ready)
        else $error("ready raised while a command runs");

endmodule

/* File: verif/flash_dev_model.sv */
`timescale 1ns/100ps
module flash_dev_model #(
    parameter logic [15:0] MAKER_CODE = 16'h1A2B, // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h3C4D  // arbitrary value
) (
    // strobes and address
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [18:0] addr,
    // data wire and operation length
    input  wire logic [15:0] host_dq,
    input  wire logic        host_dq_oe_n,
    input  wire logic [15:0] busy_ns,
    output logic      [15:0] dq
);
    logic [15:0] mem [logic [18:0]];
    logic [18:0] a_lat;
    logic [15:0] rd = 16'h0000, last = 16'h0000, pdata = 16'h0000;
    logic [2:0]  step = 3'h0;
    logic        busy = 1'b0, is_prog = 1'b0, tog = 1'b0, id_mode = 1'b0;
    realtime     t_fall = 0.0;
    wire         wsel_n = ce_n | we_n;
    wire         rsel_n = ce_n | oe_n;

    // released wire shows the inverse of the last value, not a held copy
    assign dq = !host_dq_oe_n ? host_dq : !rsel_n ? rd : ~last;

    task automatic start(input logic prog, input logic [18:0] a, input logic [18:0] m,
                         input logic [15:0] d);
        busy = 1'b1;
        is_prog = prog;
        pdata = d;
        fork begin
            #(busy_ns);
            if (prog) mem[a] = d;
            else foreach (mem[k]) if ((k & m) == (a & m)) mem[k] = 16'hFFFF;
            busy = 1'b0;
        end join_none
    endtask

    task automatic write_cmd(input logic [18:0] a, input logic [15:0] d);
        logic [7:0] c;
        c = d[7:0];
        if (busy) return;
        if (c == 8'hF0 && (step == 3'h0 || step == 3'h2)) begin
            id_mode = 1'b0;
            step = 3'h0;
        end else case (step)
            3'h0: step = (a == 19'h05555 && c == 8'hAA) ? 3'h1 : 3'h0;
            3'h1: step = (a == 19'h02AAA && c == 8'h55) ? 3'h2 : 3'h0;
            3'h2: begin
                step = a != 19'h05555 ? 3'h0 : c == 8'hA0 ? 3'h6 : c == 8'h80 ? 3'h3 : 3'h0;
                if (a == 19'h05555 && (c == 8'h90 || c == 8'h98)) id_mode = 1'b1;
            end
            3'h3: step = (a == 19'h05555 && c == 8'hAA) ? 3'h4 : 3'h0;
            3'h4: step = (a == 19'h02AAA && c == 8'h55) ? 3'h5 : 3'h0;
            3'h5: begin
                step = 3'h0;
                if (c == 8'h30) start(1'b0, a, 19'h7F800, d);
                if (c == 8'h50) start(1'b0, a, 19'h78000, d);
                if (c == 8'h10 && a == 19'h05555) start(1'b0, a, 19'h00000, d);
            end
            default: begin
                step = 3'h0;
                start(1'b1, a, 19'h7FFFF, d);
            end
        endcase
    endtask

    always @(negedge wsel_n) begin
        a_lat = addr;
        t_fall = $realtime;
    end

    // short glitches and writes with output enable low are dropped
    always @(posedge wsel_n) begin
        if (oe_n === 1'b1 && $realtime - t_fall >= 5.0) write_cmd(a_lat, host_dq);
    end

    always @(negedge rsel_n) begin
        if (busy) begin
            tog = ~tog;
            rd = {8'h00, is_prog ? ~pdata[7] : 1'b0, tog, 6'h00};
        end else if (id_mode) rd = addr[0] ? PART_CODE : MAKER_CODE;
        else rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    end

    always @(posedge rsel_n) last = rd;
endmodule

/* File: verif/parallel_flash_command_status_engine_tb_top.sv */
`timescale 1ns/100ps
`include "flash_ctl_consts.svh"
module parallel_flash_command_status_engine_tb_top;
    localparam logic [15:0] MAKER = 16'h1A2B; // arbitrary value
    localparam logic [15:0] PART  = 16'h3C4D; // arbitrary value
    logic                     sys_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
    flash_ctl_pkg::flash_op_e cmd_op = flash_ctl_pkg::OP_READ;
    logic [18:0]              cmd_addr = 19'h00000, a;
    logic [15:0]              cmd_data = 16'h0000, busy_ns = 16'h0BB8, d;
    logic [15:0]              rd_word, flash_dq_in;
    logic                     cmd_ready, done, timed_out;
    flash_ctl_pkg::pins_s     flash_pins;
    logic [15:0]              exp_mem [logic [18:0]];
    logic [18:0]              alist [$];
    logic [18:0]              masks [3] = '{19'h7F800, 19'h78000, 19'h00000};
    int                       fail_count = 0, check_count = 0, seed = 59007;

    flash_host_ctl #(.ERASE_LIMIT(200)) flash_host_ctl_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done),
        .rd_word(rd_word), .timed_out(timed_out), .flash_pins(flash_pins),
        .flash_dq_in(flash_dq_in));

    flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_dev_model_i (
        .ce_n(flash_pins.ce_n), .oe_n(flash_pins.oe_n), .we_n(flash_pins.we_n),
        .addr(flash_pins.addr), .host_dq(flash_pins.dq_out),
        .host_dq_oe_n(flash_pins.dq_oe_n), .busy_ns(busy_ns), .dq(flash_dq_in));

    initial forever #50 sys_clk = ~sys_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            fail_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [15:0] exp_word(input logic [18:0] ad);
        return exp_mem.exists(ad) ? exp_mem[ad] : 16'hFFFF;
    endfunction

    // every wait is bounded so a stuck handshake ends in the report
    task automatic issue(input flash_ctl_pkg::flash_op_e op, input logic [18:0] ad,
                         input logic [15:0] dt);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        // ready read off the edge is what the next edge samples, so no race
        while (cmd_ready !== 1'b1 && n < 4000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        cmd_op = op;
        cmd_addr = ad;
        cmd_data = dt;
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        do begin @(posedge sys_clk); #1; n++; end while (done !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            fail_count++;
            results();
        end
    endtask

    task automatic rd_chk(input logic [18:0] ad);
        issue(flash_ctl_pkg::OP_READ, ad, 16'h0000);
        check(rd_word, exp_word(ad));
    endtask

    // writes never overlap an output-enable low
    always @(negedge sys_clk) if (flash_pins.we_n === 1'b0) check({15'h0000, flash_pins.oe_n}, 16'h0001);

    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        issue(flash_ctl_pkg::OP_ID_ENTRY, 19'h00000, 16'h0000);
        issue(flash_ctl_pkg::OP_READ, 19'h00000, 16'h0000);
        check(rd_word, MAKER);
        issue(flash_ctl_pkg::OP_READ, 19'h00001, 16'h0000);
        check(rd_word, PART);
        issue(flash_ctl_pkg::OP_MODE_EXIT, 19'h00000, 16'h0000);
        rd_chk(19'h00000);
        issue(flash_ctl_pkg::OP_QUERY_ENTRY, 19'h00000, 16'h0000);
        issue(flash_ctl_pkg::OP_MODE_EXIT, 19'h00000, 16'h0000);
        rd_chk(19'h00001);
        for (int i = 0; i < 12; i++) begin
            a = i < 2 ? 19'h05555 : 19'($random(seed));
            d = i == 0 ? 16'h0000 : i == 1 ? 16'hFF7F : 16'($random(seed));
            busy_ns = 16'h012C + {3'h0, 13'($random(seed))};
            issue(flash_ctl_pkg::OP_PROGRAM, a, d);
            check({15'h0000, timed_out}, 16'h0000);
            check(rd_word, d);
            exp_mem[a] = d;
            alist.push_back(a);
            rd_chk(a);
        end
        // sector, block and chip erase in that order, so survivors can be seen
        for (int k = 0; k < 3; k++) begin
            a = alist[k * 3 + 2];
            issue(flash_ctl_pkg::flash_op_e'(3'(k + 2)), a, 16'h0000);
            check(rd_word, 16'hFFFF);
            foreach (exp_mem[j]) if ((j & masks[k]) == (a & masks[k])) exp_mem[j] = 16'hFFFF;
            foreach (alist[j]) rd_chk(alist[j]);
        end
        busy_ns = 16'h9C40;
        issue(flash_ctl_pkg::OP_PROGRAM, 19'h00123, 16'h1234);
        check({15'h0000, timed_out}, 16'h0001);
        repeat (400) @(posedge sys_clk);
        exp_mem[19'h00123] = 16'h1234;
        rd_chk(19'h00123);
        results();
    end
endmodule
